// file: evout_pkg.sv
package evout_pkg;

  // Number of relay outputs and OR slots per grouped output
  localparam int OUT_COUNT = 6;
  localparam int GROUP_OUTS = 3;
  localparam int SLOT_COUNT = 6;

  // Event vector layout, lowest index first
  localparam int EV_STATUS_BASE = 0;
  localparam int EV_ALARM_BASE = 8;
  localparam int EV_TRIP_BASE = 16;
  localparam int EV_COMM_BASE = 32;
  localparam int EV_PARAM_A = 38;
  localparam int EV_PARAM_B = 39;
  localparam int EV_THRESH_BASE = 40;
  localparam int EV_WAVE_BASE = 64;
  localparam int EV_COUNT = 66;
  localparam int SEL_W = 7;

  // Selector value that maps nothing; any code at or above EV_COUNT is idle
  localparam logic [SEL_W-1:0] SEL_NONE = 7'h7f;

  // Register map on the module bus register port
  localparam logic [15:0] STATUS_ADDR = 16'h4507;
  localparam logic [15:0] SEL_BASE = 16'h4600;
  localparam logic [15:0] COMMIT_ADDR = 16'h4640;
  localparam int COMM_LSB = 8;
  localparam int COMM_W = 6;
  localparam logic [COMM_W-1:0] COMM_RESET = 6'h00;

  // Register access request from the module bus
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  // Events delivered by the trip unit, excluding the communication bits
  typedef struct packed {
    logic [1:0] wave;
    logic [23:0] thresh;
    logic param_b;
    logic param_a;
    logic [15:0] trip;
    logic [7:0] alarm;
    logic [7:0] status;
  } events_t;

endpackage

// file: event_pick.sv
`timescale 1ns/1ps

// Picks one event out of the full event vector; idle codes give zero
module event_pick #(
  parameter int EV_W = evout_pkg::EV_COUNT
) (
  input wire logic [EV_W-1:0] events_i,
  input wire logic [evout_pkg::SEL_W-1:0] sel_i,
  output logic hit_o
);

  // Out-of-range codes mean the slot is unassigned
  always_comb begin
    if (int'(sel_i) < EV_W) begin
      hit_o = events_i[sel_i];
    end else begin
      hit_o = 1'b0;
    end
  end

endmodule

// file: event_mapped_output_module.sv
`timescale 1ns/1ps

// Function
// - Six outputs, mapped only by software
// - Outputs one-three OR up to six events
// - Outputs four-six follow one event each
// - Communication bits in status high byte
// - No configurable delay before outputs respond
// - One LED mirrors each output
// - Event set spans all listed categories
// - Separate parameter set A and B events
// - Mapping written by tool over bus
module event_mapped_output_module (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire evout_pkg::reg_req_t req_i,
  input wire evout_pkg::events_t events_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output logic [evout_pkg::OUT_COUNT-1:0] out_o,
  output logic [evout_pkg::OUT_COUNT-1:0] led_o
);

  typedef enum logic [0:0] {ST_UNCONF, ST_RUN} run_state_t;

  localparam int NO = evout_pkg::OUT_COUNT;
  localparam int NS = evout_pkg::SLOT_COUNT;
  localparam int SW = evout_pkg::SEL_W;

  // Selector address check: output in addr[5:3], slot in addr[2:0]
  function automatic logic sel_addr_ok(input logic [15:0] a);
    logic [2:0] o;
    logic [2:0] s;
    o = a[5:3];
    s = a[2:0];
    sel_addr_ok = (a[15:6] == evout_pkg::SEL_BASE[15:6]) && (o < 3'(NO)) && (s < 3'(NS))
      && ((o < 3'(evout_pkg::GROUP_OUTS)) || (s == 3'd0));
  endfunction

  run_state_t state_r, state_nxt;                 // Run/unconfigured state
  logic [SW-1:0] sel_r [NO][NS];                  // Event selectors
  logic [SW-1:0] sel_nxt [NO][NS];
  logic [evout_pkg::COMM_W-1:0] comm_r, comm_nxt; // Fieldbus communication bits
  logic [NO-1:0] out_r, out_nxt;                  // Registered output states
  logic [15:0] rdata_r, rdata_nxt;                // Read data
  logic rvalid_r, rvalid_nxt;                     // Read answer strobe
  logic [evout_pkg::EV_COUNT-1:0] ev_all;         // Full selectable event vector
  logic [NS-1:0] hit [NO];                        // Per-slot matches
  logic wr_status, wr_sel, wr_commit;             // Decoded writes

  // Assemble every selectable event category into one vector
  always_comb begin
    ev_all = {events_i.wave, events_i.thresh, events_i.param_b, events_i.param_a,
              comm_r, events_i.trip, events_i.alarm, events_i.status};
  end

  // One picker per slot of every output; outputs four-six only use slot zero
  for (genvar o = 0; o < NO; o++) begin : g_out
    for (genvar s = 0; s < NS; s++) begin : g_slot
      event_pick #(.EV_W(evout_pkg::EV_COUNT)) u_pick (
        .events_i(ev_all),
        .sel_i(sel_r[o][s]),
        .hit_o(hit[o][s])
      );
    end
  end

  // Write decode
  always_comb begin
    wr_status = req_i.wr && (req_i.addr == evout_pkg::STATUS_ADDR);
    wr_sel = req_i.wr && sel_addr_ok(req_i.addr);
    wr_commit = req_i.wr && (req_i.addr == evout_pkg::COMMIT_ADDR);
  end

  // Configuration and communication-bit next values
  always_comb begin
    state_nxt = state_r;
    comm_nxt = comm_r;
    sel_nxt = sel_r;
    if (wr_status) begin
      // Only bits 13:8 of the high byte are writable; the low byte reports outputs
      comm_nxt = req_i.wdata[evout_pkg::COMM_LSB +: evout_pkg::COMM_W];
    end
    if (wr_sel) begin
      sel_nxt[req_i.addr[5:3]][req_i.addr[2:0]] = req_i.wdata[SW-1:0];
    end
    if (wr_commit) begin
      // Bit 0 enables evaluation; clearing it drops all outputs again
      state_nxt = req_i.wdata[0] ? ST_RUN : ST_UNCONF;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= ST_UNCONF;
      comm_r <= evout_pkg::COMM_RESET;
      for (int o = 0; o < NO; o++) begin
        for (int s = 0; s < NS; s++) begin
          sel_r[o][s] <= evout_pkg::SEL_NONE;
        end
      end
    end else begin
      state_r <= state_nxt;
      comm_r <= comm_nxt;
      sel_r <= sel_nxt;
    end
  end

  // Output evaluation: a fixed one-clock register stage, no delay timer
  always_comb begin
    out_nxt = '0;
    if (state_r == ST_RUN) begin
      for (int o = 0; o < NO; o++) begin
        if (o < evout_pkg::GROUP_OUTS) begin
          out_nxt[o] = |hit[o];
        end else begin
          out_nxt[o] = hit[o][0];
        end
      end
    end
  end

  // Read data: status word, selectors, commit state; unmapped reads zero
  always_comb begin
    rdata_nxt = '0;
    rvalid_nxt = req_i.rd;
    if (req_i.rd) begin
      if (req_i.addr == evout_pkg::STATUS_ADDR) begin
        rdata_nxt[NO-1:0] = out_r;
        rdata_nxt[evout_pkg::COMM_LSB +: evout_pkg::COMM_W] = comm_r;
      end else if (sel_addr_ok(req_i.addr)) begin
        rdata_nxt[SW-1:0] = sel_r[req_i.addr[5:3]][req_i.addr[2:0]];
      end else if (req_i.addr == evout_pkg::COMMIT_ADDR) begin
        rdata_nxt[0] = (state_r == ST_RUN);
      end
    end
  end

  // Output and read registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      out_r <= '0;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // LEDs are the same flops as the relays, so they can never disagree
  always_comb begin
    out_o = out_r;
    led_o = out_r;
    rdata_o = rdata_r;
    rvalid_o = rvalid_r;
  end

  // Checks
  sequence s_comm0_write;
    wr_status && req_i.wdata[evout_pkg::COMM_LSB] && !wr_commit;
  endsequence

  sequence s_mapped_run;
    state_r == ST_RUN && sel_r[3][0] == 7'(evout_pkg::EV_COMM_BASE);
  endsequence

  AST_UNCONF_QUIET: assert property (@(posedge clk_i) disable iff (reset_i)
    state_r == ST_UNCONF |=> out_o == '0)
    else $error("output active while unconfigured");

  AST_LED_MIRROR: assert property (@(posedge clk_i) disable iff (reset_i)
    led_o == out_o)
    else $error("LED differs from output");

  AST_GROUP_OR: assert property (@(posedge clk_i) disable iff (reset_i)
    state_r == ST_RUN |=> out_o[2:0] == {|$past(hit[2]), |$past(hit[1]), |$past(hit[0])})
    else $error("grouped output not OR of its events");

  AST_SINGLE_FOLLOW: assert property (@(posedge clk_i) disable iff (reset_i)
    state_r == ST_RUN |=> out_o[5:3] == {$past(hit[5][0]), $past(hit[4][0]), $past(hit[3][0])})
    else $error("single output does not follow its event");

  AST_COMM_STORE: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_status |=> comm_r == $past(req_i.wdata[13:8]))
    else $error("communication bits not stored");

  AST_COMM_DRIVES_OUT: assert property (@(posedge clk_i) disable iff (reset_i)
    s_comm0_write ##0 s_mapped_run |-> ##2 out_o[3])
    else $error("communication bit did not reach output in two cycles");

  AST_SEL_STORE: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_sel |=> sel_r[$past(req_i.addr[5:3])][$past(req_i.addr[2:0])] == $past(req_i.wdata[6:0]))
    else $error("selector write lost");

  AST_COMMIT_RUN: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_commit && req_i.wdata[0] |=> state_r == ST_RUN)
    else $error("commit did not enable evaluation");

  AST_PARAM_B: assert property (@(posedge clk_i) disable iff (reset_i)
    state_r == ST_RUN && sel_r[3][0] == 7'(evout_pkg::EV_PARAM_B) && events_i.param_b
    && !wr_commit |=> out_o[3])
    else $error("parameter set B event not output");

  // Every read is answered exactly one edge after it is taken
  AST_READ_ANSWER: assert property (@(posedge clk_i) disable iff (reset_i)
    req_i.rd |=> rvalid_o)
    else $error("read answer missing one cycle after request");

  // The answer stands one cycle only, and the data word drops back to zero
  AST_READ_QUIET: assert property (@(posedge clk_i) disable iff (reset_i)
    !req_i.rd |=> !rvalid_o && rdata_o == 16'h0000)
    else $error("read answer without a request");

endmodule

// file: trip_unit_model.sv
`timescale 1ns/1ps

// Trip unit side: presents the event levels the output module selects from
module trip_unit_model (
  input wire logic clk_i,
  output evout_pkg::events_t events_o
);
  // All events start inactive so nothing is asserted before the bench asks
  initial begin
    events_o = '0;
  end

  // Changes only on the falling edge, keeping clear of the sampling edge
  task set_events(input evout_pkg::events_t v);
    @(negedge clk_i);
    events_o = v;
  endtask
endmodule

// file: event_mapped_output_module_tb.sv
`timescale 1ns/1ps

module event_mapped_output_module_tb;
  logic clk_i = 1'b0; // 125 MHz clock
  logic reset_i = 1'b1; // Synchronous reset
  evout_pkg::reg_req_t req_i = '0; // Register port request
  evout_pkg::events_t events_i; // Events from the trip unit model
  logic [15:0] rdata_o;
  logic rvalid_o;
  logic [evout_pkg::OUT_COUNT-1:0] out_o;
  logic [evout_pkg::OUT_COUNT-1:0] led_o;
  int miscompares = 0;
  int total_checks = 0;

  // Half period of 4 ns
  always #4 clk_i = ~clk_i;

  event_mapped_output_module dut (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i),
    .events_i(events_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .out_o(out_o), .led_o(led_o));
  trip_unit_model src (.clk_i(clk_i), .events_o(events_i));

  // Verdict and end of run
  task complete_run;
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // One-cycle write strobe, launched off the falling edge
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_i);
    req_i.addr = a;
    req_i.wdata = d;
    req_i.wr = 1'b1;
    @(negedge clk_i);
    req_i.wr = 1'b0;
  endtask

  // Answer is registered on the taking edge and checked at the next falling edge, so no wait loop is needed
  task rd(input logic [15:0] a, input logic [15:0] e);
    @(negedge clk_i);
    req_i.addr = a;
    req_i.rd = 1'b1;
    @(negedge clk_i);
    req_i.rd = 1'b0;
    check({15'h0000, rvalid_o}, 16'h0001);
    check(rdata_o, e);
  endtask

  task sel(input int o, input int s, input int e);
    wr(evout_pkg::SEL_BASE + 16'(o * 8 + s), 16'(e));
  endtask

  // Index -1 clears all; the comm gap means indices from 38 sit six bits lower
  task ev_on(input int i);
    logic [59:0] b;
    b = '0;
    if (i >= 0) b[(i < 32) ? i : i - 6] = 1'b1;
    src.set_events(evout_pkg::events_t'(b));
  endtask

  task outs(input logic [5:0] e);
    check({10'h000, out_o}, {10'h000, e});
    check({10'h000, led_o}, {10'h000, e});
  endtask

  task t_reset;
    outs(6'h00);
    rd(evout_pkg::STATUS_ADDR, 16'h0000);
    rd(evout_pkg::SEL_BASE, 16'h007f);
  endtask

  // Mapping alone must not drive outputs; only the commit bit releases them
  task t_commit;
    sel(0, 0, 0);
    ev_on(0);
    tick(1);
    outs(6'h00);
    wr(evout_pkg::COMMIT_ADDR, 16'h0001);
    outs(6'h00);
    tick(1);
    outs(6'h01);
    rd(evout_pkg::COMMIT_ADDR, 16'h0001);
    wr(evout_pkg::COMMIT_ADDR, 16'h0000);
    tick(1);
    outs(6'h00);
    wr(evout_pkg::COMMIT_ADDR, 16'h0001);
  endtask

  // Every OR slot of a grouped output, each from a different category
  task t_or;
    int evs[6];
    evs = '{8, 16, 40, 64, 38, 1};
    for (int k = 0; k < 6; k++) sel(0, k, evs[k]);
    for (int k = 0; k < 6; k++) begin
      ev_on(evs[k]);
      tick(1);
      outs(6'h01);
    end
    ev_on(-1);
    tick(1);
    outs(6'h00);
    sel(1, 5, 65);
    ev_on(65);
    tick(1);
    outs(6'h02);
  endtask

  // Single-event outputs refuse extra slots; parameter sets are distinct
  task t_single;
    sel(3, 0, 39);
    sel(4, 0, 38);
    sel(3, 1, 0);
    ev_on(0);
    tick(1);
    outs(6'h00);
    rd(evout_pkg::SEL_BASE + 16'h0019, 16'h0000);
    ev_on(39);
    tick(1);
    outs(6'h08);
    ev_on(38);
    tick(1);
    outs(6'h11);
  endtask

  // Comm bits reach their outputs two edges after the write, low byte ignored
  task t_comm;
    ev_on(-1);
    sel(5, 0, 33);
    wr(evout_pkg::STATUS_ADDR, 16'h02ff);
    outs(6'h00);
    tick(1);
    outs(6'h20);
    rd(evout_pkg::STATUS_ADDR, 16'h0220);
    sel(3, 0, 32);
    wr(evout_pkg::STATUS_ADDR, 16'h0100);
    outs(6'h20);
    tick(1);
    outs(6'h08);
  endtask

  // A reset in mid-run returns every selector, comm bit and output to idle
  task t_rerun;
    reset_i = 1'b1;
    tick(2);
    reset_i = 1'b0;
    t_reset;
  endtask

  // Guard against a hang anywhere in the sequence
  initial begin
    #400000;
    miscompares++;
    complete_run;
  end

  initial begin
    tick(6);
    reset_i = 1'b0;
    t_reset;
    t_commit;
    t_or;
    t_single;
    t_comm;
    t_rerun;
    complete_run;
  end
endmodule
